// *** verilog/adc_conversion_control.sv ***
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "adc_ctrl_map.svh"
module adc_conversion_control
    import adc_ctrl_pkg::*;
(
    input  wire logic                sys_clk_i,
    input  wire logic                nrst_i,
    input  wire logic [`ADDR_W-1:0]  addr_i,
    input  wire logic [7:0]          wr_data_i,
    input  wire logic                wr_en_i,
    input  wire logic                rd_en_i,
    output logic [7:0]               rd_data_o,
    input  wire logic [7:0]          trigger_i,
    input  wire logic                irq_ack_i,
    input  wire logic                global_irq_enable_i,
    input  wire result_t             core_result_i,
    output logic                     irq_o,
    output logic                     core_power_o,
    output logic                     core_clk_o,
    output logic                     core_convert_o,
    output logic                     core_init_o,
    output logic [3:0]               core_channel_o,
    output logic [1:0]               core_reference_o,
    output logic                     core_ref_internal_o,
    output logic                     core_ref_supply_o
);

    // Software-visible fields
    logic [1:0]  reference_select;
    logic        result_left_align;
    logic [3:0]  channel_select;
    logic        converter_enable;
    logic        auto_trigger_enable;
    logic        conversion_done_flag;
    logic        conversion_done_irq_enable;
    logic [2:0]  converter_clock_divider;
    logic [2:0]  trigger_source_select;

    // Internal state
    conv_state_e state;
    conv_state_e next_state;
    logic [4:0]  cycle_count;
    logic [4:0]  next_cycle_count;
    logic        first_pending;
    logic        trigger_prev;
    result_t     result;
    logic        result_lock;
    logic        tick;
    logic [7:0]  result_high_byte;
    logic [7:0]  result_low_byte;

    // Address match shared by strobe decode and readback selection
    function automatic logic reg_hit(input logic [`ADDR_W-1:0] a,
                                     input logic [`ADDR_W-1:0] ofs);
        reg_hit = (a == ofs);
    endfunction

    // Bus decode
    wire wr_chref = wr_en_i && reg_hit(addr_i, `OFS_CHREF);
    wire wr_ctrl  = wr_en_i && reg_hit(addr_i, `OFS_CTRL);
    wire wr_ctrlb = wr_en_i && reg_hit(addr_i, `OFS_CTRLB);
    wire rd_lo    = rd_en_i && reg_hit(addr_i, `OFS_RES_LO);
    wire rd_hi    = rd_en_i && reg_hit(addr_i, `OFS_RES_HI);

    // Enable as it will stand after this cycle's write
    wire next_enable = wr_ctrl ? wr_data_i[`EN_BIT] : converter_enable;

    // Trigger selection and edge detection
    wire free_run     = (trigger_source_select == `FREE_RUN_CODE);
    wire trigger_sel  = !free_run
                        && trigger_i[trigger_source_select];
    wire trigger_edge = trigger_sel && !trigger_prev;

    // Start requests
    wire sw_start = wr_ctrl && wr_data_i[`START_BIT]
                    && wr_data_i[`EN_BIT];
    wire hw_start = auto_trigger_enable && converter_enable
                    && trigger_edge;
    wire start_any = sw_start || hw_start;

    // Conversion length and completion
    wire [4:0] conv_target = first_pending ? `FIRST_CONV_CYCLES
                                           : `NORMAL_CONV_CYCLES;
    wire busy  = (state == ST_CONVERT);
    wire done  = busy && tick
                 && (cycle_count == conv_target - 5'd1);
    wire again = done && auto_trigger_enable && free_run;
    wire fire  = !busy && start_any && next_enable;

    // Flag clear sources; completion wins over a clear
    wire flag_clear = (wr_ctrl && wr_data_i[`FLAG_BIT])
                      || irq_ack_i;
    wire next_flag  = done ? 1'b1
                    : (flag_clear ? 1'b0 : conversion_done_flag);

    // Selection reaches the core only between conversions
    wire hold_sel = busy && !done;

    // Register readback
    wire [7:0] chref_rd = {reference_select, result_left_align, 1'b0,
                           channel_select};
    wire [7:0] ctrl_rd  = {converter_enable, busy, auto_trigger_enable,
                           conversion_done_flag,
                           conversion_done_irq_enable,
                           converter_clock_divider};
    wire [7:0] ctrlb_rd = {5'h00, trigger_source_select};

    wire [7:0] rd_mux = reg_hit(addr_i, `OFS_CHREF)  ? chref_rd
                      : reg_hit(addr_i, `OFS_CTRL)   ? ctrl_rd
                      : reg_hit(addr_i, `OFS_CTRLB)  ? ctrlb_rd
                      : reg_hit(addr_i, `OFS_RES_LO) ? result_low_byte
                      : reg_hit(addr_i, `OFS_RES_HI) ? result_high_byte
                      : 8'h00;

    // Converter clock restarts at every conversion start
    clock_prescaler u_prescaler (
        .sys_clk_i  (sys_clk_i),
        .nrst_i     (nrst_i),
        .run_i      (converter_enable),
        .restart_i  (fire || again),
        .div_code_i (converter_clock_divider),
        .tick_o     (tick)
    );

    result_presenter u_presenter (
        .result_i     (result),
        .left_align_i (result_left_align),
        .high_o       (result_high_byte),
        .low_o        (result_low_byte)
    );

    // Conversion sequencer
    always_comb begin
        next_state       = state;
        next_cycle_count = cycle_count;
        case (state)
            ST_OFF: begin
                if (fire) begin
                    next_state       = ST_CONVERT;
                    next_cycle_count = 5'd0;
                end else if (next_enable) begin
                    next_state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (fire) begin
                    next_state       = ST_CONVERT;
                    next_cycle_count = 5'd0;
                end
            end
            ST_CONVERT: begin
                if (again) begin
                    next_cycle_count = 5'd0;
                end else if (done) begin
                    next_state       = ST_IDLE;
                    next_cycle_count = 5'd0;
                end else if (tick) begin
                    next_cycle_count = cycle_count + 5'd1;
                end
            end
            default: begin
                next_state       = ST_OFF;
                next_cycle_count = 5'd0;
            end
        endcase
        if (!next_enable) begin
            next_state       = ST_OFF;
            next_cycle_count = 5'd0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state       <= ST_OFF;
            cycle_count <= 5'd0;
        end else begin
            state       <= next_state;
            cycle_count <= next_cycle_count;
        end
    end

    // First conversion after enabling runs the long initialisation
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            first_pending <= 1'b1;
        end else if (!converter_enable) begin
            first_pending <= 1'b1;
        end else if (done) begin
            first_pending <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            trigger_prev <= 1'b0;
        end else begin
            trigger_prev <= trigger_sel;
        end
    end

    // Channel/reference register
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reference_select  <= 2'(`CHREF_RESET >> `REF_LO);
            result_left_align <= 1'b0;
            channel_select    <= 4'h0;
        end else if (wr_chref) begin
            reference_select  <= wr_data_i[`REF_HI:`REF_LO];
            result_left_align <= wr_data_i[`ALIGN_BIT];
            channel_select    <= wr_data_i[`CH_HI:0];
        end
    end

    // Control/status register
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            converter_enable           <= 1'b0;
            auto_trigger_enable        <= 1'b0;
            conversion_done_irq_enable <= 1'b0;
            converter_clock_divider    <= 3'h0;
        end else if (wr_ctrl) begin
            converter_enable           <= wr_data_i[`EN_BIT];
            auto_trigger_enable        <= wr_data_i[`ATE_BIT];
            conversion_done_irq_enable <= wr_data_i[`IE_BIT];
            converter_clock_divider    <= wr_data_i[`DIV_HI:0];
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            conversion_done_flag <= 1'b0;
        end else begin
            conversion_done_flag <= next_flag;
        end
    end

    // Trigger source register
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            trigger_source_select <= 3'h0;
        end else if (wr_ctrlb) begin
            trigger_source_select <= wr_data_i[`TS_HI:0];
        end
    end

    // Result capture, frozen between low and high byte reads
    wire capture = done && !result_lock;

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            result <= 10'h000;
        end else if (capture) begin
            result <= core_result_i & `RESULT_MAX;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            result_lock <= 1'b0;
        end else if (rd_hi) begin
            result_lock <= 1'b0;
        end else if (rd_lo) begin
            result_lock <= 1'b1;
        end
    end

    // Read data stands only in the cycle after the strobe
    wire [7:0] next_rd_data = rd_en_i ? rd_mux : 8'h00;
    wire       next_irq     = next_flag && conversion_done_irq_enable
                              && global_irq_enable_i;

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_data_o <= 8'h00;
        end else begin
            rd_data_o <= next_rd_data;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= next_irq;
        end
    end

    // Analog core controls
    wire ref_internal = (reference_select == `REF_INTERNAL);
    wire ref_supply   = (reference_select == `REF_SUPPLY);
    wire next_convert = (next_state == ST_CONVERT);
    // Init marks only the long first conversion, not a free-running follower
    wire next_init    = next_convert
                        && ((first_pending && !done) || !converter_enable);

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            core_channel_o   <= 4'h0;
            core_reference_o <= 2'h0;
        end else if (!hold_sel) begin
            core_channel_o   <= channel_select;
            core_reference_o <= reference_select;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            core_ref_internal_o <= 1'b0;
            core_ref_supply_o   <= 1'b0;
        end else if (!hold_sel) begin
            core_ref_internal_o <= ref_internal;
            core_ref_supply_o   <= ref_supply;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            core_power_o <= 1'b0;
        end else begin
            core_power_o <= next_enable;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            core_clk_o <= 1'b0;
        end else begin
            core_clk_o <= tick;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            core_convert_o <= 1'b0;
        end else begin
            core_convert_o <= next_convert;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            core_init_o <= 1'b0;
        end else begin
            core_init_o <= next_init;
        end
    end

endmodule

// *** verilog/adc_ctrl_map.svh ***
// Functional notes
// - Result code is input times 1024 over reference; 0x000 ground, 0x3FF full scale.
// - Reference field 7:6: 00 external pin, 01 analog supply, 10 reserved, 11 internal.
// - Reference or channel change during a conversion applies only after it completes.
// - Alignment bit 5 picks left or right adjust, effective immediately on reads.
// - Bit 4 of the channel/reference register reads zero and ignores writes.
// - Channel codes 0-7 pins, 1110 bandgap, 1111 ground, others reserved.
// - Enable bit 7 powers the converter; clearing it aborts a running conversion.
// - First conversion after enabling takes 25 converter clocks, later ones 13.
// - Start bit reads one while converting, zero after; writing zero does nothing.
// - With auto-trigger enabled, each rising trigger edge starts a conversion; edges arriving during a running conversion are ignored.
// - Done flag sets at completion; cleared by vector acknowledge or writing one.
// - Interrupt requested only when flag, its enable and global enable are set.
// - Divider field: 000 and 001 divide by 2, then 4 up to 128.
// - Right adjust: high byte holds bits 9:8; left: high 9:2, low 1:0 at 7:6.
// - After low byte read, result is frozen until high byte is read.
// - Free running restarts a conversion right after each completion.
// - Trigger select picks the source; code 000 is free running, no trigger event.
`ifndef ADC_CTRL_MAP_SVH
`define ADC_CTRL_MAP_SVH

`define ADDR_W             3
`define OFS_CHREF          3'h0
`define OFS_CTRL           3'h1
`define OFS_CTRLB          3'h2
`define OFS_RES_LO         3'h3
`define OFS_RES_HI         3'h4

`define CHREF_RESET        8'h00
`define CTRL_RESET         8'h00
`define CTRLB_RESET        8'h00

`define REF_HI             7
`define REF_LO             6
`define ALIGN_BIT          5
`define CH_HI              3
`define EN_BIT             7
`define START_BIT          6
`define ATE_BIT            5
`define FLAG_BIT           4
`define IE_BIT             3
`define DIV_HI             2
`define TS_HI              2

`define REF_SUPPLY         2'h1
`define REF_INTERNAL       2'h3
`define FREE_RUN_CODE      3'h0

`define FIRST_CONV_CYCLES  5'd25
`define NORMAL_CONV_CYCLES 5'd13
`define RESULT_MAX         10'h3FF

`endif

// *** verilog/adc_ctrl_pkg.sv ***
package adc_ctrl_pkg;

    typedef enum logic [1:0] {
        ST_OFF,
        ST_IDLE,
        ST_CONVERT
    } conv_state_e;

    typedef logic [9:0] result_t;

endpackage

// *** verilog/clock_prescaler.sv ***
`timescale 1ns/1ps
module clock_prescaler (
    input  wire logic       sys_clk_i,
    input  wire logic       nrst_i,
    input  wire logic       run_i,
    input  wire logic       restart_i,
    input  wire logic [2:0] div_code_i,
    output logic            tick_o
);

    logic [6:0] count;
    wire  [6:0] limit;

    // Terminal count is divide factor minus one
    function automatic logic [6:0] div_limit(input logic [2:0] code);
        logic [7:0] factor;
        factor = 8'h01 << code;
        if (code < 3'h2) begin
            div_limit = 7'h01;
        end else begin
            div_limit = factor[6:0] - 7'h01;
        end
    endfunction

    assign limit = div_limit(div_code_i);

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            count  <= 7'h00;
            tick_o <= 1'b0;
        end else if (!run_i || restart_i) begin
            count  <= 7'h00;
            tick_o <= 1'b0;
        end else if (count >= limit) begin
            count  <= 7'h00;
            tick_o <= 1'b1;
        end else begin
            count  <= count + 7'h01;
            tick_o <= 1'b0;
        end
    end

endmodule

// *** verilog/result_presenter.sv ***
`timescale 1ns/1ps
module result_presenter
    import adc_ctrl_pkg::*;
(
    input  wire result_t    result_i,
    input  wire logic       left_align_i,
    output logic [7:0]      high_o,
    output logic [7:0]      low_o
);

    // Alignment is applied at read time, so it acts immediately
    assign high_o = left_align_i ? result_i[9:2]
                                 : {6'h00, result_i[9:8]};
    assign low_o  = left_align_i ? {result_i[1:0], 6'h00}
                                 : result_i[7:0];

endmodule

// *** verif/adc_ctrl_properties.sv ***
`timescale 1ns/1ps
`include "adc_ctrl_map.svh"
module adc_ctrl_properties
    import adc_ctrl_pkg::*;
(
    input wire logic               sys_clk_i,
    input wire logic               nrst_i,
    input wire logic [`ADDR_W-1:0] addr_i,
    input wire logic [7:0]         wr_data_i,
    input wire logic               wr_en_i,
    input wire logic               rd_en_i,
    input wire logic [7:0]         rd_data_o,
    input wire logic [7:0]         trigger_i,
    input wire logic               irq_ack_i,
    input wire logic               global_irq_enable_i,
    input wire result_t            core_result_i,
    input wire logic               irq_o,
    input wire logic               core_power_o,
    input wire logic               core_clk_o,
    input wire logic               core_convert_o,
    input wire logic               core_init_o,
    input wire logic [3:0]         core_channel_o,
    input wire logic [1:0]         core_reference_o,
    input wire logic               core_ref_internal_o,
    input wire logic               core_ref_supply_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    sequence ctrl_wr_s;
        wr_en_i && addr_i == `OFS_CTRL;
    endsequence
    sequence first_start_s;
        ctrl_wr_s ##0 (wr_data_i[7:6] == 2'h3 && !core_power_o);
    endsequence

    first_conv_init_a: assert property (
        first_start_s |=> (core_convert_o && core_init_o)[*2])
        else $error("first conversion did not start with init");
    disable_abort_a: assert property (
        ctrl_wr_s ##0 !wr_data_i[7] |=> !core_power_o && !core_convert_o)
        else $error("disable did not abort");
    convert_power_a: assert property (core_convert_o |-> core_power_o)
        else $error("converting while off");
    tick_spacing_a: assert property (core_clk_o |=> !core_clk_o)
        else $error("converter clock faster than divide by two");
    held_select_a: assert property (
        core_convert_o && $past(core_convert_o) && !core_clk_o
        |-> $stable(core_channel_o) && $stable(core_reference_o))
        else $error("selection changed during conversion");
    unused_bit_a: assert property (
        rd_en_i && addr_i == `OFS_CHREF |=> !rd_data_o[4])
        else $error("unused bit read one");
    irq_global_a: assert property (irq_o |-> $past(global_irq_enable_i))
        else $error("interrupt without global enable");
    ref_internal_a: assert property (
        core_ref_internal_o == (core_reference_o == `REF_INTERNAL))
        else $error("internal reference decode wrong");
    ref_supply_a: assert property (
        core_ref_supply_o == (core_reference_o == `REF_SUPPLY))
        else $error("supply reference decode wrong");
endmodule

bind adc_conversion_control adc_ctrl_properties chk_u (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .trigger_i(trigger_i),
    .irq_ack_i(irq_ack_i), .global_irq_enable_i(global_irq_enable_i),
    .core_result_i(core_result_i), .irq_o(irq_o), .core_power_o(core_power_o),
    .core_clk_o(core_clk_o), .core_convert_o(core_convert_o), .core_init_o(core_init_o),
    .core_channel_o(core_channel_o), .core_reference_o(core_reference_o),
    .core_ref_internal_o(core_ref_internal_o), .core_ref_supply_o(core_ref_supply_o)
);

// *** verif/analog_core_model.sv ***
`timescale 1ns/1ps
module analog_core_model
    import adc_ctrl_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic       convert_i,
    input  wire logic [3:0] channel_i,
    input  wire logic [1:0] reference_i,
    input  wire result_t    salt_i,
    output result_t         result_o
);
    initial result_o = 10'h000;
    // Code follows held input and reference; toggles when not converting
    always @(posedge sys_clk_i) begin
        if (convert_i) begin
            result_o <= {reference_i, channel_i, 4'h0} ^ salt_i;
        end else begin
            result_o <= ~result_o;
        end
    end
endmodule

// *** verif/tb.sv ***
`timescale 1ns/1ps
`include "adc_ctrl_map.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
    $display("FAIL %s expected %h seen %h", nm, e, g); end end
module tb;
    import adc_ctrl_pkg::*;
    logic       sys_clk_i = 0, nrst_i = 0, wr_en_i = 0, rd_en_i = 0;
    logic       irq_ack_i = 0, global_irq_enable_i = 0;
    logic [2:0] addr_i = 3'h0;
    logic [7:0] wr_data_i = 8'h00, trigger_i = 8'h00, rd_data_o;
    logic       irq_o, core_power_o, core_clk_o, core_convert_o, core_init_o;
    logic       core_ref_internal_o, core_ref_supply_o;
    logic [3:0] core_channel_o;
    logic [1:0] core_reference_o;
    result_t    core_result_i, salt = 10'h000;
    int         mismatches = 0, compares = 0;

    always #12.5 sys_clk_i = ~sys_clk_i;

    adc_conversion_control dut_u (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
        .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
        .trigger_i(trigger_i), .irq_ack_i(irq_ack_i),
        .global_irq_enable_i(global_irq_enable_i), .core_result_i(core_result_i),
        .irq_o(irq_o), .core_power_o(core_power_o), .core_clk_o(core_clk_o),
        .core_convert_o(core_convert_o), .core_init_o(core_init_o),
        .core_channel_o(core_channel_o), .core_reference_o(core_reference_o),
        .core_ref_internal_o(core_ref_internal_o), .core_ref_supply_o(core_ref_supply_o));
    analog_core_model core_u (.sys_clk_i(sys_clk_i), .convert_i(core_convert_o),
        .channel_i(core_channel_o), .reference_i(core_reference_o), .salt_i(salt),
        .result_o(core_result_i));

    function automatic int div_of(int c);
        return (c < 2) ? 2 : (1 << c);
    endfunction
    function automatic result_t exp_res(logic [7:0] sel, result_t s);
        return {sel[7:6], sel[3:0], 4'h0} ^ s;
    endfunction

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_en_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_en_i <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_en_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_en_i <= 1'b0;
        #1 d = rd_data_o;
    endtask
    task automatic chk_rd(input logic [2:0] a, input logic [7:0] e, input string nm);
        logic [7:0] d;
        rd(a, d);
        `CHK(nm, e, d)
    endtask
    // Counts ticks of one conversion and the spacing of the last two
    task automatic run_conv(output int nt, output int sp);
        int last;
        logic was;
        nt = 0;
        sp = 0;
        last = 0;
        was = 1'b0;
        for (int t = 0; t < 4000 && (t < 2 || core_convert_o); t++) begin
            @(posedge sys_clk_i);
            #1;
            // The last tick shows as the conversion drops
            if (core_clk_o && (core_convert_o || was)) begin
                if (nt > 0) sp = t - last;
                last = t;
                nt++;
            end
            was = core_convert_o;
        end
    endtask
    task automatic give_verdict;
        if (mismatches == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk_i);
        mismatches++;
        give_verdict();
    end

    initial begin
        logic [7:0] v, d;
        result_t    res;
        int         nt, sp;
        void'($urandom(32'h0389));
        repeat (6) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        for (int a = 0; a < 8; a++) chk_rd(a[2:0], 8'h00, "reset");
        repeat (4) begin
            v = 8'($urandom);
            wr(`OFS_CHREF, v);
            chk_rd(`OFS_CHREF, v & 8'hEF, "chref");
        end
        for (int c = 0; c < 8; c++) begin
            wr(`OFS_CTRL, 8'hC0 | c[7:0]);
            run_conv(nt, sp);
            `CHK("first ticks", 25, nt)
            `CHK("divider", div_of(c), sp)
            chk_rd(`OFS_CTRL, 8'h90 | c[7:0], "done");
            wr(`OFS_CTRL, 8'hD0 | c[7:0]);
            run_conv(nt, sp);
            `CHK("next ticks", 13, nt)
            wr(`OFS_CTRL, 8'h10);
            chk_rd(`OFS_CTRL, 8'h00, "off");
        end
        // Selection written mid-conversion must not reach this result
        v = 8'($urandom) & 8'hDF;
        wr(`OFS_CHREF, v);
        salt <= 10'($urandom);
        wr(`OFS_CTRL, 8'hC1);
        res = exp_res(v, salt);
        repeat (10) @(posedge sys_clk_i);
        wr(`OFS_CHREF, ~v & 8'hDF);
        #1 `CHK("held channel", v[3:0], core_channel_o)
        run_conv(nt, sp);
        chk_rd(`OFS_RES_LO, res[7:0], "low right");
        chk_rd(`OFS_RES_HI, {6'h00, res[9:8]}, "high right");
        wr(`OFS_CHREF, v | 8'h20);
        chk_rd(`OFS_RES_HI, res[9:2], "high left");
        chk_rd(`OFS_RES_LO, {res[1:0], 6'h00}, "low left");
        salt = 10'($urandom);
        wr(`OFS_CTRL, 8'hD1);
        run_conv(nt, sp);
        chk_rd(`OFS_RES_HI, res[9:2], "frozen");
        wr(`OFS_CTRL, 8'hD1);
        run_conv(nt, sp);
        res = exp_res(v, salt);
        chk_rd(`OFS_RES_HI, res[9:2], "fresh");
        global_irq_enable_i <= 1'b1;
        wr(`OFS_CTRL, 8'h89);
        repeat (3) @(posedge sys_clk_i);
        `CHK("irq on", 1'b1, irq_o)
        global_irq_enable_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        `CHK("irq global", 1'b0, irq_o)
        global_irq_enable_i <= 1'b1;
        irq_ack_i <= 1'b1;
        @(posedge sys_clk_i);
        irq_ack_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        `CHK("irq ack", 1'b0, irq_o)
        wr(`OFS_CTRLB, 8'h03);
        wr(`OFS_CTRL, 8'hA1);
        trigger_i <= 8'($urandom) & 8'hF7;
        repeat (4) @(posedge sys_clk_i);
        `CHK("other trigger", 1'b0, core_convert_o)
        trigger_i[3] <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        `CHK("trigger start", 1'b1, core_convert_o)
        run_conv(nt, sp);
        wr(`OFS_CTRLB, 8'h00);
        repeat (5) @(posedge sys_clk_i);
        `CHK("no free trigger", 1'b0, core_convert_o)
        wr(`OFS_CTRL, 8'hF1);
        repeat (80) @(posedge sys_clk_i);
        chk_rd(`OFS_CTRL, 8'hF1, "free run");
        `CHK("free running", 1'b1, core_convert_o)
        wr(`OFS_CTRL, 8'h00);
        #1 `CHK("abort", 1'b0, core_convert_o)
        give_verdict();
    end
endmodule
